// File: rtl/host_link_pkg.sv
// host link package: constants shared by the module end and the host end
// assumes a 250 MHz system clock on both ends
package host_link_pkg;
  localparam int unsigned CLK_HZ          = 250_000_000; // system clock rate
  localparam int unsigned BAUD_MIN        = 9600;        // slowest uart / spi rate
  localparam int unsigned BAUD_MAX        = 6_000_000;   // fastest uart / spi rate
  localparam int unsigned BAUD_DEFAULT    = 115200;      // factory uart rate
  localparam int unsigned HOST_SAFE_BAUD  = 1_000_000;   // host advised to stay below
  localparam int unsigned DIV_W           = 16;          // baud divisor width
  // divisor = rounded clock / rate; 115200 gives 2170 cycles per bit
  localparam logic [15:0] DIV_DEFAULT     = 16'((CLK_HZ + BAUD_DEFAULT / 2) / BAUD_DEFAULT);
  localparam logic [15:0] DIV_MIN         = 16'(CLK_HZ / BAUD_MAX);
  localparam logic [1:0]  SLIP_MAX        = 2'h2;        // bytes allowed after stop request
  localparam logic [1:0]  PAR_NONE        = 2'h0;        // parity encodings
  localparam logic [1:0]  PAR_ODD         = 2'h1;
  localparam logic [1:0]  PAR_EVEN        = 2'h2;
  localparam logic        DATA9_DEFAULT   = 1'b0;        // 8 data bits
  localparam logic        STOP2_DEFAULT   = 1'b0;        // one stop bit
  localparam logic        FLOW_DEFAULT    = 1'b1;        // handshake on
  localparam logic        LINK_UART       = 1'b0;        // host link select
  localparam logic        LINK_SPI        = 1'b1;
  localparam logic        UNIT_DEFAULT    = 1'b0;        // serial unit zero
  localparam logic        LOC_DEFAULT     = 1'b0;        // pin location zero
endpackage : host_link_pkg

// File: rtl/host_link_if.sv
// host link interface: uart pins, handshake pads, spi pins and notify pad
// assumes both ends share clk; the bench resolves no tristates since all pins are one-way
`timescale 1ns/10ps
interface host_link_if;
  logic txd;            // module to host serial data
  logic rxd;            // host to module serial data
  logic handshake_pad_a; // module cts out to host, low = host may send
  logic handshake_pad_b; // host rts in, high = module must stop
  logic sclk;           // spi clock from host
  logic cs_n;           // spi chip select from host
  logic mosi;           // host to module spi data
  logic miso;           // module to host spi data
  logic miso_oe;        // module drives miso while selected
  logic host_notify_pad; // module has data queued
  modport module_end (output txd, input rxd, output handshake_pad_a, input handshake_pad_b,
                      input sclk, input cs_n, input mosi, output miso, output miso_oe,
                      output host_notify_pad);
  modport host_end (input txd, output rxd, input handshake_pad_a, output handshake_pad_b,
                    output sclk, output cs_n, output mosi, input miso, input miso_oe,
                    input host_notify_pad);
endinterface : host_link_if

// File: rtl/module_link.sv
// module end of the host link: uart (default) or spi slave with notify pad
// assumes pins arrive asynchronously; control via plain register port; one byte buffer per direction
// Overview of operation
// - uart is active link out of reset
// - baud programmable 9600 to 6M, default 115200
// - 8/9 bits, none/odd/even parity, 1/2 stops
// - divisor rounds requested rate, small error
// - handshake default on, up to two slip bytes
// - host tolerates extra byte after stop
// - host prefers rates below 1 Mbps
// - host cts on pad a, rts on pad b
// - uart transmits and receives simultaneously
// - spi stays disabled until enabled
// - spi acts only as slave
// - spi polarity and phase configurable
// - spi words msb first
// - notify pad asserted while data queued in enabled spi mode
// - master reads when notify seen
// - no firmware update path over host link
`timescale 1ns/10ps
module module_link
  import host_link_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // register port
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // link pins
  host_link_if.module_end  link
);
  // register indexes (word addresses on the plain port)
  localparam logic [3:0] A_CTRL = 4'h0, A_DIV = 4'h1, A_TX = 4'h2, A_RX = 4'h3, A_STAT = 4'h4;
  // ctrl bits: 0 link, 1 data9, 3:2 parity, 4 stop2, 5 flow, 6 cpol, 7 cpha, 8 spi_en, 9 reads as constant 1
  typedef enum logic [2:0] {T_IDLE = 3'b001, T_SHIFT = 3'b010, T_STOP = 3'b100} tx_e;

  typedef struct packed {
    logic        link_sel; logic data9; logic [1:0] par; logic stop2; logic flow;
    logic        cpol; logic cpha; logic spi_en;
    logic [15:0] div;
    logic [8:0]  tx_buf; logic tx_full;
    logic [8:0]  rx_buf; logic rx_full; logic rx_err;
    tx_e         tst; logic [15:0] tcnt; logic [3:0] tbit; logic [11:0] tsh;
    logic [1:0]  slip;
    logic        rbusy; logic [15:0] rcnt; logic [3:0] rbit; logic [10:0] rsh;
    logic [2:0]  s1; logic [2:0] s2; logic [2:0] s3; // rxd/rts/sclk syncs
    logic [1:0]  c1; logic [1:0] c2;                 // cs_n/mosi syncs
    logic [7:0]  ssh; logic [2:0] scnt; logic miso;
    logic [31:0] rdata;
  } st_s;
  st_s r, n;

  // frame length: data bits + parity, without start and stop bits
  function automatic logic [3:0] nbits(input st_s s);
    nbits = 4'(s.data9 ? 9 : 8) + 4'(s.par != PAR_NONE);
  endfunction

  // next-state logic for registers, uart and spi slave
  always_comb begin
    logic rx_s, rts_s, sck_s, sck_p, cs_s, mosi_s, edge_s, parb, smp;
    edge_s = 1'b0; parb = 1'b0; smp = 1'b0;
    n = r;
    // two-flop syncs then one extra stage for edge detection
    n.s1 = {link.sclk, link.handshake_pad_b, link.rxd};
    n.s2 = r.s1; n.s3 = r.s2;
    n.c1 = {link.cs_n, link.mosi}; n.c2 = r.c1;
    rx_s = r.s2[0]; rts_s = r.s2[1]; sck_s = r.s2[2]; sck_p = r.s3[2];
    cs_s = r.c2[1]; mosi_s = r.c2[0];
    n.rdata = 32'h0;
    // register writes; spi enable only by explicit write
    if (wr_i) begin
      case (addr_i)
        A_CTRL: begin
          n.link_sel = wdata_i[0]; n.data9 = wdata_i[1]; n.par = wdata_i[3:2];
          n.stop2 = wdata_i[4]; n.flow = wdata_i[5]; n.cpol = wdata_i[6]; n.cpha = wdata_i[7];
          n.spi_en = wdata_i[8];
        end
        A_DIV: n.div = (wdata_i[15:0] < DIV_MIN) ? DIV_MIN : wdata_i[15:0];
        A_TX: if (!r.tx_full) begin
          n.tx_buf = wdata_i[8:0]; n.tx_full = 1'b1;
        end
        default: ;
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        A_CTRL: n.rdata = {22'h0, 1'b1, r.spi_en, r.cpha, r.cpol, r.flow, r.stop2, r.par, r.data9, r.link_sel};
        A_DIV:  n.rdata = {16'h0, r.div};
        A_RX:   begin
          n.rdata = {22'h0, r.rx_err, r.rx_buf}; n.rx_full = 1'b0;
        end
        A_STAT: n.rdata = {27'h0, r.tst != T_IDLE, r.slip == SLIP_MAX, r.rx_err, r.rx_full, r.tx_full};
        default: n.rdata = 32'h0;
      endcase
    end
    // uart transmitter, runs alongside the receiver
    parb = (r.par == PAR_ODD) ? ~^r.tx_buf[7:0] ^ (r.data9 & r.tx_buf[8]) : ^r.tx_buf[7:0] ^ (r.data9 & r.tx_buf[8]);
    case (r.tst)
      T_IDLE: begin
        if (!rts_s) n.slip = 2'h0; // host grants again
        if (r.link_sel == LINK_UART && r.tx_full && (!r.flow || !rts_s || r.slip < SLIP_MAX)) begin
          if (r.flow && rts_s) n.slip = r.slip + 2'h1; // slips while stop propagates
          n.tsh = r.data9 ? {parb, r.tx_buf, 1'b0, 1'b1} : {1'b1, parb, r.tx_buf[7:0], 1'b0, 1'b1};
          n.tsh = {n.tsh[10:0], 1'b0} >> 1; // start bit in lsb
          if (r.data9) n.tsh = {1'b1, parb, r.tx_buf, 1'b0};
          else n.tsh = {2'b11, parb, r.tx_buf[7:0], 1'b0};
          if (r.par == PAR_NONE) n.tsh = r.data9 ? {2'b11, r.tx_buf, 1'b0} : {3'b111, r.tx_buf[7:0], 1'b0};
          n.tx_full = 1'b0; n.tst = T_SHIFT; n.tcnt = r.div; n.tbit = 4'h0;
        end
      end
      T_SHIFT: begin
        n.tcnt = r.tcnt - 16'h1;
        if (r.tcnt == 16'h1) begin
          n.tcnt = r.div; n.tsh = {1'b1, r.tsh[11:1]}; n.tbit = r.tbit + 4'h1;
          if (r.tbit == nbits(r)) n.tst = T_STOP;
        end
      end
      T_STOP: begin
        n.tcnt = r.tcnt - 16'h1;
        if (r.tcnt == 16'h1) begin
          n.tcnt = r.div; n.tbit = r.tbit + 4'h1;
          if (r.tbit == nbits(r) + 4'(r.stop2) + 4'h1) n.tst = T_IDLE;
        end
      end
      default: n.tst = T_IDLE;
    endcase
    // uart receiver, samples at mid-bit
    if (r.link_sel == LINK_UART) begin
      if (!r.rbusy) begin
        if (!rx_s) begin
          n.rbusy = 1'b1; n.rcnt = {1'b0, r.div[15:1]}; n.rbit = 4'h0;
        end
      end else begin
        n.rcnt = r.rcnt - 16'h1;
        if (r.rcnt == 16'h0) begin
          n.rcnt = r.div - 16'h1; n.rbit = r.rbit + 4'h1;
          n.rsh = {rx_s, r.rsh[10:1]};
          if (r.rbit == 4'h0 && rx_s) n.rbusy = 1'b0; // false start
          if (r.rbit == nbits(r) + 4'h1) begin
            n.rbusy = 1'b0; n.rx_full = 1'b1;
            n.rx_buf = r.data9 ? r.rsh[10:2] : {1'b0, r.rsh[10:3]};
            smp = r.data9 ? ^r.rsh[10:2] : ^r.rsh[10:3];
            n.rx_err = !rx_s || (r.par != PAR_NONE && (smp ^ rx_s ^ (r.par == PAR_ODD))) ;
            if (r.par != PAR_NONE) begin
              n.rx_buf = r.data9 ? r.rsh[9:1] : {1'b0, r.rsh[9:2]};
              n.rx_err = !rx_s || ((r.data9 ? ^r.rsh[9:1] : ^r.rsh[9:2]) ^ r.rsh[10] ^ (r.par == PAR_ODD));
            end
          end
        end
      end
    end
    // spi slave, msb first, mode from cpol/cpha
    edge_s = (sck_s ^ r.cpol) != (sck_p ^ r.cpol);
    if (r.link_sel == LINK_SPI && r.spi_en) begin
      if (cs_s) begin
        n.scnt = 3'h0; n.ssh = r.tx_buf[7:0]; n.miso = r.tx_buf[7];
      end else if (edge_s) begin
        if (((sck_s ^ r.cpol) == 1'b1) != r.cpha) begin // sample edge
          n.ssh = {r.ssh[6:0], mosi_s}; n.scnt = r.scnt + 3'h1;
          if (r.scnt == 3'h7) begin
            n.rx_buf = {1'b0, r.ssh[6:0], mosi_s}; n.rx_full = 1'b1; n.tx_full = 1'b0;
          end
        end else n.miso = r.ssh[7];
      end
    end
  end

  // state register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
      r.link_sel <= LINK_UART; r.flow <= FLOW_DEFAULT; r.div <= DIV_DEFAULT;
      r.data9 <= DATA9_DEFAULT; r.par <= PAR_NONE; r.stop2 <= STOP2_DEFAULT;
      // sync stages start at the idle pin levels (rxd high, rts low, sclk low): no false edge
      r.tst <= T_IDLE; r.tsh <= 12'hfff; r.s1 <= 3'h1; r.s2 <= 3'h1; r.s3 <= 3'h1;
      r.c1 <= 2'h3; r.c2 <= 2'h3;
    end else begin
      r <= n;
    end
  end

  // outputs
  assign link.txd = (r.tst == T_IDLE) ? 1'b1 : r.tsh[0];
  assign link.handshake_pad_a = r.flow & r.rx_full;
  assign link.miso = r.miso;
  assign link.miso_oe = r.link_sel == LINK_SPI && r.spi_en && !r.c2[1];
  assign link.host_notify_pad = r.link_sel == LINK_SPI && r.spi_en && r.tx_full;
  assign rdata_o = r.rdata;
endmodule : module_link

// File: rtl/host_link.sv
// host end of the link: uart peer with rts/cts, plus spi master reading on notify
// assumes module pins are asynchronous; orders via plain register port
`timescale 1ns/10ps
module host_link
  import host_link_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // register port
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // link pins
  host_link_if.host_end    link
);
  localparam logic [3:0] A_CTRL = 4'h0, A_DIV = 4'h1, A_TX = 4'h2, A_RX = 4'h3;
  typedef struct packed {
    logic        spi; logic cpol; logic stop_rq; logic [15:0] div;
    logic [8:0]  tx; logic tx_full; logic [7:0] rx; logic rx_full;
    logic [15:0] cnt; logic [3:0] bits; logic busy; logic [9:0] sh; logic sclk; logic cs_n;
    logic [3:0]  rs1; logic [3:0] rs2; // txd, notify, cts, miso syncs
    logic        rbusy; logic [15:0] rcnt; logic [3:0] rbit; logic [8:0] rsh; // 8n1 receiver
    logic [31:0] rdata;
  } st_s;
  st_s r, n;

  // host side: 8n1 uart and mode-0/2 spi master (msb first)
  always_comb begin
    n = r;
    // every module pin passes two flops before any logic reads it
    n.rs1 = {link.miso, link.handshake_pad_a, link.host_notify_pad, link.txd}; n.rs2 = r.rs1;
    n.rdata = 32'h0;
    if (wr_i) begin
      case (addr_i)
        A_CTRL: begin
          n.spi = wdata_i[0]; n.cpol = wdata_i[6]; n.stop_rq = wdata_i[1];
        end
        A_DIV: n.div = wdata_i[15:0];
        A_TX: begin
          n.tx = wdata_i[8:0]; n.tx_full = 1'b1;
        end
        default: ;
      endcase
    end
    if (rd_i) begin
      n.rdata = (addr_i == A_RX) ? {23'h0, r.rx_full, r.rx} : {30'h0, r.busy, r.tx_full};
      if (addr_i == A_RX) n.rx_full = 1'b0;
    end
    if (!r.busy) begin
      if (r.spi && r.rs2[1]) begin
        n.busy = 1'b1; n.cs_n = 1'b0; n.cnt = r.div; n.bits = 4'h0; n.sh = 10'h0;
      end else if (!r.spi && r.tx_full && !r.rs2[2]) begin
        n.busy = 1'b1; n.sh = {1'b1, r.tx[7:0], 1'b0}; n.cnt = r.div; n.bits = 4'h0; n.tx_full = 1'b0;
      end
    end else begin
      n.cnt = r.cnt - 16'h1;
      if (r.cnt == 16'h1) begin
        n.cnt = r.div;
        if (r.spi) begin
          n.sclk = ~r.sclk;
          if (!r.sclk) n.sh = {r.sh[8:0], r.rs2[3]};
          else begin
            n.bits = r.bits + 4'h1;
            if (r.bits == 4'h7) begin
              n.busy = 1'b0; n.cs_n = 1'b1; n.rx = r.sh[7:0]; n.rx_full = 1'b1;
            end
          end
        end else begin
          n.sh = {1'b1, r.sh[9:1]}; n.bits = r.bits + 4'h1;
          if (r.bits == 4'h9) n.busy = 1'b0;
        end
      end
    end
    // 8n1 receiver on txd, mid-bit sampling; a new byte overwrites an unread one
    if (!r.rbusy) begin
      if (!r.rs2[0]) begin
        n.rbusy = 1'b1; n.rcnt = {1'b0, r.div[15:1]}; n.rbit = 4'h0;
      end
    end else begin
      n.rcnt = r.rcnt - 16'h1;
      if (r.rcnt == 16'h0) begin
        n.rcnt = r.div - 16'h1; n.rbit = r.rbit + 4'h1;
        n.rsh = {r.rs2[0], r.rsh[8:1]};
        if (r.rbit == 4'h0 && r.rs2[0]) n.rbusy = 1'b0; // false start
        if (r.rbit == 4'h9) begin
          n.rbusy = 1'b0; n.rx = r.rsh[8:1]; n.rx_full = 1'b1;
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
      r.div <= DIV_DEFAULT; r.sh <= 10'h3ff; r.cs_n <= 1'b1; r.rs1 <= 4'h1; r.rs2 <= 4'h1;
    end else begin
      r <= n;
    end
  end

  assign link.rxd = r.spi ? 1'b1 : r.sh[0];
  assign link.handshake_pad_b = r.stop_rq;
  assign link.sclk = r.sclk ^ r.cpol;
  assign link.cs_n = r.cs_n;
  assign link.mosi = r.sh[9];
  assign rdata_o = r.rdata;
endmodule : host_link

// File: tb/host_link_checker.sv
// wire checks on the host link between the module end and the host end
// assumes one clock domain and instantiation beside the interface in the bench
`timescale 1ns/10ps
module host_link_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link wires
  input wire logic txd,
  input wire logic rxd,
  input wire logic handshake_pad_a,
  input wire logic handshake_pad_b,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic miso_oe,
  input wire logic host_notify_pad
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // both lines idle high, nothing driven, right after reset
  reset_idle_a: assert property ($fell(rst_i) |-> txd && rxd && !handshake_pad_a && !miso_oe && !host_notify_pad)
    else $error("link not idle after reset");
  // a start bit lasts at least eight clocks since the divisor floor is far above that
  start_bit_a: assert property ($fell(txd) |-> !txd [*8])
    else $error("start bit too short");
  // a frame never holds the line low for ever
  line_return_a: assert property ($fell(txd) |-> ##[1:1000] txd)
    else $error("txd stuck low");
  // the stop request only rises once a byte has landed, i.e. in its stop bit
  cts_after_rx_a: assert property ($rose(handshake_pad_a) |-> rxd)
    else $error("cts raised outside stop bit");
  // host keeps quiet while told to stop; six clocks cover the synchroniser lag
  host_holds_a: assert property (handshake_pad_a [*6] |=> !$fell(rxd))
    else $error("host sent while stopped");
  // the slave releases miso once deselected
  oe_release_a: assert property (cs_n [*6] |=> !miso_oe)
    else $error("miso driven while deselected");
  // the slave only starts driving when selected
  oe_select_a: assert property ($rose(miso_oe) |-> !cs_n)
    else $error("miso driven without select");
  // no clock edges outside a selected transfer
  sclk_quiet_a: assert property (cs_n && $past(cs_n) |-> $stable(sclk))
    else $error("sclk moved while deselected");
  // the master answers a notify within a bounded time
  notify_served_a: assert property ($rose(host_notify_pad) |-> ##[1:300] !cs_n)
    else $error("notify not served");
endmodule : host_link_checker

// File: tb/host_serial_interface_tb.sv
// testbench joining the module end and the host end over the link interface
// assumes registered read data one cycle after the read strobe on both ends
`timescale 1ns/10ps
module host_serial_interface_tb import host_link_pkg::*;;
  localparam logic [15:0] BIT_DIV = 16'h0030; // short bit time keeps the run brief
  logic        clk_i        = 1'b0;           // system clock
  logic        rst_i        = 1'b1;           // async reset
  logic [3:0]  addr  [2]    = '{4'h0, 4'h0};  // index 0 module end, 1 host end
  logic [31:0] wdata [2]    = '{32'h0, 32'h0};
  logic        wr    [2]    = '{1'b0, 1'b0};
  logic        rd    [2]    = '{1'b0, 1'b0};
  logic [31:0] rdata [2];
  logic [31:0] q;                              // scratch read value
  logic [31:0] q2;
  int          miscompares  = 0;
  int          n_checks     = 0;

  // free running clock
  always #2 clk_i = ~clk_i;

  host_link_if link_bus ();
  module_link i_module_link (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr[0]), .wdata_i(wdata[0]), .wr_i(wr[0]),
    .rd_i(rd[0]), .rdata_o(rdata[0]), .link(link_bus.module_end));
  host_link i_host_link (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr[1]), .wdata_i(wdata[1]), .wr_i(wr[1]),
    .rd_i(rd[1]), .rdata_o(rdata[1]), .link(link_bus.host_end));
  host_link_checker i_host_link_checker (.clk_i(clk_i), .rst_i(rst_i), .txd(link_bus.txd), .rxd(link_bus.rxd),
    .handshake_pad_a(link_bus.handshake_pad_a), .handshake_pad_b(link_bus.handshake_pad_b), .sclk(link_bus.sclk),
    .cs_n(link_bus.cs_n), .miso_oe(link_bus.miso_oe), .host_notify_pad(link_bus.host_notify_pad));

  // one register cycle; read data is taken just after the following edge
  task automatic acc(input bit h, input bit w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    addr[h]  <= a;
    wdata[h] <= d;
    wr[h]    <= w;
    rd[h]    <= !w;
    @(posedge clk_i);
    wr[h] <= 1'b0;
    rd[h] <= 1'b0;
    #1 r = rdata[h];
    @(posedge clk_i);
  endtask : acc

  // compare one value
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h got %h", nm, e, g);
    end
  endtask : chk

  // read until masked bits match, bounded so a hang is reported
  task automatic poll(input bit h, input logic [3:0] a, input logic [31:0] m, input logic [31:0] want,
                      output logic [31:0] r);
    int i;
    for (i = 0; i < 3000; i++) begin
      acc(h, 1'b0, a, 32'h0, r);
      if ((r & m) === want) break;
    end
    if (i == 3000) chk("poll", want, r & m);
  endtask : poll

  // watch one module frame on txd, sampling mid bit on the falling clock edge
  task automatic frame(input logic d9, input logic [1:0] par, input logic st, input logic [8:0] d);
    logic [12:0] e;
    int          n;
    int          k;
    e = '1;
    e[0] = 1'b0;
    n = d9 ? 10 : 9;
    for (k = 1; k < n; k++) e[k] = d[k-1];
    if (par !== PAR_NONE) begin
      e[n] = (par === PAR_ODD) ? ~^d : ^d;
      n++;
    end
    n = n + (st ? 2 : 1);
    @(negedge clk_i);
    for (k = 0; k < 400 && link_bus.txd !== 1'b0; k++) @(negedge clk_i);
    repeat (BIT_DIV / 2) @(negedge clk_i);
    for (k = 0; k < n; k++) begin
      chk("txd bit", 32'(e[k]), 32'(link_bus.txd));
      repeat (BIT_DIV) @(negedge clk_i);
    end
    @(posedge clk_i);
  endtask : frame

  // reset values of the module registers
  task automatic test_reset;
    acc(0, 1'b0, 4'h0, 32'h0, q);
    chk("ctrl", 32'h0000_0220, q);
    acc(0, 1'b0, 4'h1, 32'h0, q);
    chk("div", 32'(DIV_DEFAULT), q);
    acc(0, 1'b0, 4'h4, 32'h0, q);
    chk("stat", 32'h0, q);
    $display("test reset done");
  endtask : test_reset

  // both directions at once
  task automatic test_duplex;
    acc(0, 1'b1, 4'h1, 32'(BIT_DIV), q);
    acc(1, 1'b1, 4'h1, 32'(BIT_DIV), q);
    fork
      acc(0, 1'b1, 4'h2, 32'h05a, q);
      acc(1, 1'b1, 4'h2, 32'h0c3, q2);
    join
    poll(1, 4'h3, 32'h100, 32'h100, q);
    chk("host rx", 32'h15a, q);
    poll(0, 4'h4, 32'h2, 32'h2, q);
    chk("cts", 32'h1, 32'(link_bus.handshake_pad_a));
    acc(0, 1'b0, 4'h3, 32'h0, q);
    chk("module rx", 32'h0c3, q);
    $display("test duplex done");
  endtask : test_duplex

  // every parity code, both data widths and both stop counts on the wire
  task automatic test_frames;
    logic [1:0] par;
    logic [8:0] d;
    for (int i = 0; i < 4; i++) begin
      par = 2'(i % 3);
      d = (9'h1a5 ^ 9'(i * 37)) & (i[0] ? 9'h1ff : 9'h0ff);
      acc(0, 1'b1, 4'h0, 32'h20 | 32'(i[1]) << 4 | 32'(par) << 2 | 32'(i[0]) << 1, q);
      acc(0, 1'b0, 4'h0, 32'h0, q);
      chk("ctrl rb", 32'h220 | 32'(i[1]) << 4 | 32'(par) << 2 | 32'(i[0]) << 1, q);
      acc(0, 1'b1, 4'h2, 32'(d), q);
      frame(i[0], par, i[1], d);
      acc(1, 1'b0, 4'h3, 32'h0, q);
    end
    acc(0, 1'b1, 4'h0, 32'h20, q);
    $display("test frames done");
  endtask : test_frames

  // stop request: two bytes slip, the third waits for release
  task automatic test_flow;
    acc(1, 1'b1, 4'h0, 32'h2, q);
    for (int k = 0; k < 3; k++) begin
      poll(0, 4'h4, 32'h1, 32'h0, q);
      acc(0, 1'b1, 4'h2, 32'h30 + k, q);
    end
    poll(0, 4'h4, 32'h19, 32'h09, q);
    chk("notify off", 32'h0, 32'(link_bus.host_notify_pad));
    acc(1, 1'b0, 4'h3, 32'h0, q);
    acc(1, 1'b1, 4'h0, 32'h0, q);
    poll(1, 4'h3, 32'h100, 32'h100, q);
    chk("held byte", 32'h132, q);
    $display("test flow done");
  endtask : test_flow

  // spi slave byte fetched by the host on notify
  task automatic test_spi;
    acc(1, 1'b1, 4'h1, 32'h8, q);
    acc(1, 1'b1, 4'h0, 32'h1, q);
    acc(0, 1'b1, 4'h0, 32'h121, q);
    acc(0, 1'b1, 4'h2, 32'h096, q);
    poll(1, 4'h3, 32'h100, 32'h100, q);
    chk("spi byte", 32'h196, q);
    poll(0, 4'h4, 32'h1, 32'h0, q);
    chk("notify drop", 32'h0, 32'(link_bus.host_notify_pad));
    $display("test spi done");
  endtask : test_spi

  // verdict and end of run
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop

  // main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    test_reset();
    test_duplex();
    test_frames();
    test_flow();
    test_spi();
    report_and_stop();
  end

  // hang guard, well above the expected run length
  initial begin
    repeat (80000) @(posedge clk_i);
    miscompares++;
    report_and_stop();
  end
endmodule : host_serial_interface_tb
